// File: rtl/energy_detect_power_control.sv
// Energy-detect power manager with its control and status register
//
// Rules of the energy-detect feature; R9 and R17 are left to software
// R1: Energy-detect transitions only while enable set
// R2: Wake enabled and activity count reached: power up
// R3: Sleep enabled and no energy: power down
// R4: Manual toggle starts transition, self-clears
// R5: Manual toggle ignores thresholds and timers
// R6: Burst of four pulses per power-up
// R7: Burst disable sends a single pulse
// R8: Powered state bit shows current power state
// R9: Software ignores powered state when disabled
// R10: Error limit only sets flag, no power action
// R11: Error flag sticky until register read
// R12: Activity flag set when count meets limit
// R13: Register read clears activity flag
// R14: Four-bit error limit field, reset one
// R15: Four-bit activity limit field, reset one
// R16: Counters clear after two seconds without data
// R17: Software disables crossover when autoneg off
// R18: Error flag set when error count meets limit
// R19: Clocked decisions, reset to powered-down defaults
`timescale 1ns/1ps
module energy_detect_power_control import energy_sense_pkg::*; #(
	parameter logic [SILENCE_W-1:0] SILENCE_CYCLES = SILENCE_CYC
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [4:0] regAddr,
	input wire logic regWrEn,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic regRdEn,
	input wire logic energyEvent,
	input wire logic errorEvent,
	input wire logic energyPresent,
	output logic [DATA_W-1:0] regRdData,
	output logic poweredUp,
	output logic edPulse
);

	function automatic logic hit(input logic [4:0] addr, input logic en);
		hit = en && (addr == CTRL_ADDR);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Line inputs come from the analog front end, so they are synchronised first
	localparam int LANES = 2;
	localparam int LANE_DATA = 0;
	localparam int LANE_ERR = 1;
	logic [LANES-1:0] laneIn, laneEv;
	logic [1:0] presSync_r, presSync_nxt;
	logic dataEv, errEv, energyNow;

	assign laneIn[LANE_DATA] = energyEvent;
	assign laneIn[LANE_ERR] = errorEvent;

	// Both event lanes have one shape: two flops to settle, a third to find the edge
	for (genvar g = 0; g < LANES; g++) begin : gLane
		logic [2:0] sync_r, sync_nxt;

		always_comb begin
			sync_nxt = {sync_r[1:0], laneIn[g]};
		end

		always_ff @(posedge ref_clk or negedge rstn) begin
			if (!rstn) begin
				sync_r <= 3'h0;
			end else begin
				sync_r <= sync_nxt;
			end
		end

		// Edges are taken between stage two and three, never from stage one
		assign laneEv[g] = sync_r[1] & ~sync_r[2];
	end

	// Level input: no edge stage needed, two flops are enough
	always_comb begin
		presSync_nxt = {presSync_r[0], energyPresent};
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			presSync_r <= 2'h0;
		end else begin
			presSync_r <= presSync_nxt;
		end
	end

	assign dataEv = laneEv[LANE_DATA];
	assign errEv = laneEv[LANE_ERR];
	assign energyNow = presSync_r[1];

	////////////////////////////////////////////////////////////////////////////////
	// Control register
	ctrl_s ctrl_r, ctrl_nxt;
	logic manReq_r, manReq_nxt;
	logic wrHit, rdHit;

	// Writes land on the next edge, so a read in the same cycle shows the old value
	assign wrHit = hit(regAddr, regWrEn);
	assign rdHit = hit(regAddr, regRdEn);

	always_comb begin
		ctrl_nxt = ctrl_r;
		manReq_nxt = 1'b0; // see R4
		if (wrHit) begin
			ctrl_nxt.enable = regWrData[EN_BIT];
			ctrl_nxt.wakeOnActivity = regWrData[WAKE_BIT];
			ctrl_nxt.sleepOnSilence = regWrData[SLEEP_BIT];
			ctrl_nxt.burstDisable = regWrData[BURST_DIS_BIT];
			ctrl_nxt.errorLimit = regWrData[ERR_LIM_HI:ERR_LIM_LO]; // see R14
			ctrl_nxt.activityLimit = regWrData[ACT_LIM_HI:ACT_LIM_LO]; // see R15
			manReq_nxt = regWrData[MAN_BIT]; // see R4
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r <= CTRL_RST; // see R14 see R15
			manReq_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			manReq_r <= manReq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Event counters, silence timer and sticky threshold flags
	logic [3:0] dataCnt_r, dataCnt_nxt;
	logic [3:0] errCnt_r, errCnt_nxt;
	logic [SILENCE_W-1:0] quiet_r, quiet_nxt;
	logic actMet_r, actMet_nxt;
	logic errMet_r, errMet_nxt;
	logic actReached, errReached, powerStart;

	// A zero limit is met at once, which is the plain reading of "equals or exceeds"
	assign actReached = (dataCnt_r >= ctrl_r.activityLimit); // see R12
	assign errReached = (errCnt_r >= ctrl_r.errorLimit); // see R18

	always_comb begin
		dataCnt_nxt = dataCnt_r;
		errCnt_nxt = errCnt_r;
		quiet_nxt = quiet_r;
		actMet_nxt = actMet_r;
		errMet_nxt = errMet_r;
		// Only data events restart the quiet timer; error events are not activity
		if (dataEv) begin
			quiet_nxt = '0;
			if (dataCnt_r != CNT_MAX) begin
				dataCnt_nxt = dataCnt_r + 1'b1;
			end
		end else if (quiet_r >= SILENCE_CYCLES - 1'b1) begin
			// Isolated noise events age out instead of adding up forever
			quiet_nxt = '0;
			dataCnt_nxt = 4'h0; // see R16
			errCnt_nxt = 4'h0; // see R16
		end else begin
			quiet_nxt = quiet_r + 1'b1;
		end
		// Error events only feed their flag; nothing here reaches the state machine
		if (errEv && errCnt_r != CNT_MAX) begin
			errCnt_nxt = errCnt_r + 1'b1;
		end
		// A fresh power-up starts counting from zero so it does not retrigger
		if (powerStart) begin
			dataCnt_nxt = 4'h0;
		end
		if (rdHit) begin
			actMet_nxt = 1'b0; // see R13
			errMet_nxt = 1'b0; // see R11
		end
		// Set wins over a read in the same cycle
		if (ctrl_r.enable && actReached) begin
			actMet_nxt = 1'b1; // see R12
		end
		if (ctrl_r.enable && errReached) begin
			errMet_nxt = 1'b1; // see R10 see R18
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			dataCnt_r <= 4'h0;
			errCnt_r <= 4'h0;
			quiet_r <= '0;
			actMet_r <= 1'b0;
			errMet_r <= 1'b0;
		end else begin
			dataCnt_r <= dataCnt_nxt;
			errCnt_r <= errCnt_nxt;
			quiet_r <= quiet_nxt;
			actMet_r <= actMet_nxt;
			errMet_r <= errMet_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power state machine; error counts never feed it
	pwr_e pwr_r, pwr_nxt;
	logic pulseStart_r, pulseStart_nxt;
	logic manFlip, autoUp, autoDown;

	// Manual request outranks both automatic paths, so software gets its flip whenever enable is set
	assign manFlip = manReq_r; // see R5
	assign autoUp = ctrl_r.wakeOnActivity && actReached; // see R2
	assign autoDown = ctrl_r.sleepOnSilence && !energyNow; // see R3

	// Limitation: a manual request written while disabled is dropped, not queued
	always_comb begin
		pwr_nxt = pwr_r;
		if (ctrl_r.enable) begin // see R1
			case (pwr_r)
				PWR_DOWN: begin
					if (manFlip) begin
						pwr_nxt = PWR_UP; // see R5
					end else if (autoUp) begin
						pwr_nxt = PWR_UP; // see R2
					end
				end
				PWR_UP: begin
					if (manFlip) begin
						pwr_nxt = PWR_DOWN; // see R5
					end else if (autoDown) begin
						pwr_nxt = PWR_DOWN; // see R3
					end
				end
				default: begin
					pwr_nxt = PWR_DOWN;
				end
			endcase
		end
	end

	assign powerStart = (pwr_r == PWR_DOWN) && (pwr_nxt == PWR_UP);
	assign pulseStart_nxt = powerStart;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pwr_r <= PWR_DOWN; // see R19
			pulseStart_r <= 1'b0;
		end else begin
			pwr_r <= pwr_nxt; // see R19
			pulseStart_r <= pulseStart_nxt;
		end
	end

	// A power-up during a running burst restarts it from the first pulse
	energy_pulse_gen pulseGen (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.start(pulseStart_r),
		.single(ctrl_r.burstDisable), // see R7
		.pulseOut(edPulse)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Read data and power output; unmapped reads return zero
	logic [DATA_W-1:0] rdData_r, rdData_nxt;
	logic pwrOut_r, pwrOut_nxt;

	// Trade-off: read data is registered, so it stands one cycle after the strobe
	function automatic logic [DATA_W-1:0] statusWord(input ctrl_s c, input logic man,
		input logic up, input logic errFlag, input logic actFlag);
		logic [DATA_W-1:0] w;
		w = '0;
		w[EN_BIT] = c.enable;
		w[WAKE_BIT] = c.wakeOnActivity;
		w[SLEEP_BIT] = c.sleepOnSilence;
		w[MAN_BIT] = man; // see R4
		w[BURST_DIS_BIT] = c.burstDisable;
		w[PWR_BIT] = up; // see R8
		w[ERR_MET_BIT] = errFlag; // see R11
		w[ACT_MET_BIT] = actFlag; // see R13
		w[ERR_LIM_HI:ERR_LIM_LO] = c.errorLimit;
		w[ACT_LIM_HI:ACT_LIM_LO] = c.activityLimit;
		return w;
	endfunction

	always_comb begin
		rdData_nxt = '0;
		if (rdHit) begin
			rdData_nxt = statusWord(ctrl_r, manReq_r, pwr_r == PWR_UP, errMet_r, actMet_r);
		end
		pwrOut_nxt = (pwr_nxt == PWR_UP); // see R8
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdData_r <= '0;
			pwrOut_r <= 1'b0;
		end else begin
			rdData_r <= rdData_nxt;
			pwrOut_r <= pwrOut_nxt;
		end
	end

	assign regRdData = rdData_r;
	// pwrOut_r loads pwr_nxt on the same edge as pwr_r, so the two never differ
	assign poweredUp = pwrOut_r;

endmodule // energy_detect_power_control

// File: rtl/energy_pulse_gen.sv
// Energy-detect pulse burst generator fired on each power-up
`timescale 1ns/1ps
module energy_pulse_gen import energy_sense_pkg::*; (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic single,
	output logic pulseOut
);

	pulse_e state_r, state_nxt;
	logic [2:0] left_r, left_nxt;
	logic [TMR_W-1:0] tmr_r, tmr_nxt;
	logic pulse_r, pulse_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// A new start restarts the burst; a power cycle mid-burst gets a fresh one
	always_comb begin
		state_nxt = state_r;
		left_nxt = left_r;
		tmr_nxt = tmr_r;
		pulse_nxt = 1'b0;
		if (start) begin
			state_nxt = PG_HIGH;
			left_nxt = single ? SINGLE_LEN : BURST_LEN; // see R6 see R7
			tmr_nxt = PULSE_CYC;
			pulse_nxt = 1'b1;
		end else begin
			case (state_r)
				PG_IDLE: begin
					state_nxt = PG_IDLE;
				end
				PG_HIGH: begin
					pulse_nxt = 1'b1;
					tmr_nxt = tmr_r - 1'b1;
					if (tmr_r == 1'b1) begin
						pulse_nxt = 1'b0;
						left_nxt = left_r - 1'b1;
						tmr_nxt = GAP_CYC;
						state_nxt = (left_r == 1'b1) ? PG_IDLE : PG_GAP;
					end
				end
				PG_GAP: begin
					tmr_nxt = tmr_r - 1'b1;
					if (tmr_r == 1'b1) begin
						tmr_nxt = PULSE_CYC;
						pulse_nxt = 1'b1;
						state_nxt = PG_HIGH;
					end
				end
				default: begin
					state_nxt = PG_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= PG_IDLE;
			left_r <= 3'h0;
			tmr_r <= '0;
			pulse_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			left_r <= left_nxt;
			tmr_r <= tmr_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	assign pulseOut = pulse_r;

endmodule // energy_pulse_gen

// File: rtl/energy_sense_pkg.sv
// Constants, field layout and types shared by the energy-detect power manager
package energy_sense_pkg;

	// Register map
	localparam logic [4:0] CTRL_ADDR = 5'h1D;
	localparam int DATA_W = 16;

	// Field positions of activity_sense_control
	localparam int EN_BIT = 15;
	localparam int WAKE_BIT = 14;
	localparam int SLEEP_BIT = 13;
	localparam int MAN_BIT = 12;
	localparam int BURST_DIS_BIT = 11;
	localparam int PWR_BIT = 10;
	localparam int ERR_MET_BIT = 9;
	localparam int ACT_MET_BIT = 8;
	localparam int ERR_LIM_HI = 7;
	localparam int ERR_LIM_LO = 4;
	localparam int ACT_LIM_HI = 3;
	localparam int ACT_LIM_LO = 0;

	// Reset values of the writable fields, and the ceiling of the event counters
	localparam logic EN_RST = 1'b0;
	localparam logic WAKE_RST = 1'b1;
	localparam logic SLEEP_RST = 1'b1;
	localparam logic BURST_DIS_RST = 1'b0;
	localparam logic [3:0] ERR_LIM_RST = 4'h1;
	localparam logic [3:0] ACT_LIM_RST = 4'h1;
	localparam logic [3:0] CNT_MAX = 4'hF;

	// Timing
	localparam longint CLK_HZ = 40_000_000;
	localparam int CLK_NS = 25;
	localparam longint SILENCE_S = 2;
	localparam longint SILENCE_CYC_L = SILENCE_S * CLK_HZ;
	localparam int SILENCE_W = 27;
	localparam logic [SILENCE_W-1:0] SILENCE_CYC = SILENCE_CYC_L[SILENCE_W-1:0];
	localparam int PULSE_NS = 100;
	localparam int GAP_NS = 1000;
	localparam int PULSE_CYC_I = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_CYC_I = (GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam int TMR_W = 6;
	localparam logic [TMR_W-1:0] PULSE_CYC = PULSE_CYC_I[TMR_W-1:0];
	localparam logic [TMR_W-1:0] GAP_CYC = GAP_CYC_I[TMR_W-1:0];
	localparam logic [2:0] BURST_LEN = 3'h4;
	localparam logic [2:0] SINGLE_LEN = 3'h1;

	// Software-visible control fields
	typedef struct packed {
		logic enable;
		logic wakeOnActivity;
		logic sleepOnSilence;
		logic burstDisable;
		logic [3:0] errorLimit;
		logic [3:0] activityLimit;
	} ctrl_s;

	localparam ctrl_s CTRL_RST = '{EN_RST, WAKE_RST, SLEEP_RST, BURST_DIS_RST,
		ERR_LIM_RST, ACT_LIM_RST};

	typedef enum logic [1:0] {
		PWR_DOWN = 2'b01,
		PWR_UP = 2'b10
	} pwr_e;

	typedef enum logic [2:0] {
		PG_IDLE = 3'b001,
		PG_HIGH = 3'b010,
		PG_GAP = 3'b100
	} pulse_e;

endpackage

// File: sim/energy_detect_power_control_properties.sv
// Port checks of the energy-detect power manager
`timescale 1ns/1ps
module energy_detect_power_control_properties import energy_sense_pkg::*; #(
	parameter logic [SILENCE_W-1:0] SILENCE_CYCLES = SILENCE_CYC
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [4:0] regAddr,
	input wire logic regWrEn,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic regRdEn,
	input wire logic energyEvent,
	input wire logic errorEvent,
	input wire logic energyPresent,
	input wire logic [DATA_W-1:0] regRdData,
	input wire logic poweredUp,
	input wire logic edPulse
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	logic ctrlWr, ctrlRd, en_r, en_nxt;
	assign ctrlWr = regWrEn && regAddr == CTRL_ADDR;
	assign ctrlRd = regRdEn && regAddr == CTRL_ADDR;
	// Shadow of the enable bit, built from writes since the port hides the register
	always_comb begin
		en_nxt = ctrlWr ? regWrData[EN_BIT] : en_r;
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			en_r <= 1'b0;
		end else begin
			en_r <= en_nxt;
		end
	end
	////////////////////////////////////////////////////////////////
	a_off_disabled: assert property ((!en_r)[*3] |=> $stable(poweredUp))
		else $error("power state moved while disabled");
	a_manual_flip: assert property (ctrlWr && regWrData[EN_BIT] && regWrData[MAN_BIT]
		|-> ##2 poweredUp != $past(poweredUp, 2)) else $error("manual toggle ignored");
	a_manual_clear: assert property ($past(ctrlRd)
		|-> regRdData[MAN_BIT] == $past(ctrlWr && regWrData[MAN_BIT], 2))
		else $error("manual bit not self clearing");
	a_pulse_width: assert property ($rose(edPulse) |-> edPulse[*4] ##1 !edPulse)
		else $error("pulse width wrong");
	a_pulse_gap: assert property ($fell(edPulse) |-> !edPulse throughout (1'b1 ##39 1'b1))
		else $error("pulse gap too short");
	a_pulse_start: assert property ($rose(poweredUp) |=> $rose(edPulse))
		else $error("no pulse on power up");
	a_pulse_powered: assert property ($rose(edPulse) |-> poweredUp)
		else $error("pulse while powered down");
	a_read_idle: assert property (!$past(ctrlRd) |-> regRdData == 16'h0000)
		else $error("read data not zero");
	a_read_power: assert property ($past(ctrlRd) && regRdData[EN_BIT]
		|-> regRdData[PWR_BIT] == $past(poweredUp)) else $error("power bit mismatch");
	c_up: cover property ($rose(poweredUp));
	c_down: cover property ($fell(poweredUp));
	c_err_flag: cover property ($past(ctrlRd) && regRdData[ERR_MET_BIT]);
endmodule // energy_detect_power_control_properties

bind energy_detect_power_control energy_detect_power_control_properties #(
	.SILENCE_CYCLES(SILENCE_CYCLES)) CHK (.ref_clk, .rstn, .regAddr, .regWrEn, .regWrData,
	.regRdEn, .energyEvent, .errorEvent, .energyPresent, .regRdData, .poweredUp, .edPulse);

// File: sim/energy_detect_power_control_tb.sv
// Self-checking bench of the energy-detect power manager
`timescale 1ns/1ps
module energy_detect_power_control_tb import energy_sense_pkg::*;;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [4:0] regAddr = 5'h00;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [DATA_W-1:0] regWrData = 16'h0000;
	logic [DATA_W-1:0] regRdData;
	logic energyEvent, errorEvent, energyPresent, poweredUp, edPulse;
	logic rdPend = 1'b0;
	int errors = 0;
	int comparisons = 0;
	int pulses = 0;
	logic [3:0] lim;
	logic [DATA_W-1:0] expQ[$];
	always #12.5 ref_clk = ~ref_clk;
	always @(posedge edPulse) pulses++;
	line_model LINE (.ref_clk, .energyEvent, .errorEvent, .energyPresent);
	// Short silence timeout keeps the run small
	energy_detect_power_control #(.SILENCE_CYCLES(27'h00000C8)) DUT (.ref_clk, .rstn, .regAddr,
		.regWrEn, .regWrData, .regRdEn, .energyEvent, .errorEvent, .energyPresent, .regRdData,
		.poweredUp, .edPulse);
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [DATA_W-1:0] d, input logic [4:0] a = CTRL_ADDR);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
	endtask
	task automatic rd(input logic [DATA_W-1:0] exp, input logic [4:0] a = CTRL_ADDR);
		@(posedge ref_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		expQ.push_back(exp);
		@(posedge ref_clk);
		regRdEn <= 1'b0;
	endtask
	task automatic waitPwr(input logic v);
		int n;
		n = 0;
		while (poweredUp !== v && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
		check({15'h0000, poweredUp}, {15'h0000, v});
		if (n >= 400) summarize();
	endtask
	// Read data is settled by the falling edge in the middle of the answer cycle
	always @(negedge ref_clk) begin
		if (rdPend) check(regRdData, expQ.pop_front());
		rdPend = regRdEn;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hBFF0E78A));
		lim = 4'(2 + $urandom % 3);
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(16'h6011);
		rd(16'h0000, 5'h1C);
		wr(16'h4744);
		rd(16'h4044);
		LINE.burst(0, 5);
		rd(16'h4044);
		check({15'h0000, poweredUp}, 16'h0000);
		repeat (250) @(posedge ref_clk);
		// Crossover setting lives outside this block
		wr(16'hC020 | lim);
		LINE.burst(0, lim - 1);
		repeat (8) @(posedge ref_clk);
		check({15'h0000, poweredUp}, 16'h0000);
		pulses = 0;
		LINE.burst(0, 1);
		waitPwr(1'b1);
		repeat (200) @(posedge ref_clk);
		check(16'(pulses), 16'h0004);
		rd(16'hC520 | lim);
		rd(16'hC420 | lim);
		LINE.burst(0, 1);
		LINE.burst(1, 2);
		repeat (250) @(posedge ref_clk);
		rd(16'hC620 | lim);
		rd(16'hC420 | lim);
		wr(16'hA020 | lim);
		LINE.level(1'b0);
		waitPwr(1'b0);
		// Software reads the power bit only while enabled
		rd(16'hA020 | lim);
		pulses = 0;
		wr(16'h98FF);
		waitPwr(1'b1);
		repeat (60) @(posedge ref_clk);
		check(16'(pulses), 16'h0001);
		rd(16'h8CFF);
		wr(16'h98FF);
		waitPwr(1'b0);
		wr(16'hC0F2);
		LINE.burst(0, 1);
		repeat (250) @(posedge ref_clk);
		LINE.burst(0, 1);
		repeat (8) @(posedge ref_clk);
		check({15'h0000, poweredUp}, 16'h0000);
		LINE.burst(0, 1);
		waitPwr(1'b1);
		repeat (4) @(posedge ref_clk);
		// Reset in mid-burst must drop back to the powered-down defaults
		rstn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check({15'h0000, poweredUp}, 16'h0000);
		check({15'h0000, edPulse}, 16'h0000);
		rstn <= 1'b1;
		rd(16'h6011);
		repeat (4) @(posedge ref_clk);
		summarize();
	end
endmodule // energy_detect_power_control_tb

// File: sim/line_model.sv
// Cable line model: data events, error events and energy level
`timescale 1ns/1ps
module line_model (
	input wire logic ref_clk,
	output logic energyEvent,
	output logic errorEvent,
	output logic energyPresent
);
	initial begin
		energyEvent = 1'b0;
		errorEvent = 1'b0;
		energyPresent = 1'b1;
	end
	// Three cycles high and three low between pulses so the input synchroniser never misses a pulse
	task automatic burst(input bit err, input int n);
		repeat (n) begin
			@(posedge ref_clk);
			errorEvent <= err;
			energyEvent <= !err;
			repeat (3) @(posedge ref_clk);
			errorEvent <= 1'b0;
			energyEvent <= 1'b0;
			repeat (2) @(posedge ref_clk);
		end
	endtask
	task automatic level(input logic v);
		@(posedge ref_clk);
		energyPresent <= v;
	endtask
endmodule // line_model
